// File: include/feedback_cfg.svh
// constants of the feedback table pointer block
`ifndef FEEDBACK_CFG_SVH
`define FEEDBACK_CFG_SVH

`define FT_PTR_MSR_ADDR   32'h0000_17D0
`define FT_PTR_RESET      64'h0000_0000_0000_0000
`define FT_PTR_VALID_BIT  0
`define FT_PTR_PAGE_LSB   12
`define FT_ROW_ALIGN      8
`define FT_THERM_READY_BIT 26
`define FT_SIZE_EDX_LSB   8
`define FT_SIZE_EDX_MSB   11

`endif

// File: include/feedback_pkg.sv
// types shared by the feedback table modules
package feedback_pkg;

  typedef enum logic [1:0] {
    WR_IDLE,
    WR_ISSUE,
    WR_DONE
  } writer_state_t;

  typedef logic [7:0] cap_byte_t;

endpackage

// File: include/table_wr_if.sv
// carrier between the pointer block and its row writer
`timescale 1ns/1ps
interface table_wr_if #(
  parameter int PHYS_ADDR_WIDTH = 46,
  parameter int ROW_W           = 8,
  parameter int CAP_BYTES       = 8
);
  logic                       start;
  logic                       abort;
  logic [ROW_W-1:0]           row;
  logic [PHYS_ADDR_WIDTH-13:0] page;
  logic [8*CAP_BYTES-1:0]     caps;
  logic                       busy;
  logic                       done;
  logic                       mem_req;
  logic [PHYS_ADDR_WIDTH-1:0] mem_addr;
  logic [7:0]                 mem_data;
  logic                       mem_ack;

  modport ctrl (
    output start, abort, row, page, caps, mem_ack,
    input  busy, done, mem_req, mem_addr, mem_data
  );
  modport writer (
    input  start, abort, row, page, caps, mem_ack,
    output busy, done, mem_req, mem_addr, mem_data
  );
endinterface

// File: hw/row_writer.sv
// walks one processor row of capability bytes out to memory
`timescale 1ns/1ps
`include "feedback_cfg.svh"
module row_writer
  import feedback_pkg::*;
#(
  parameter int PHYS_ADDR_WIDTH = 46,
  parameter int ROW_W           = 8,
  parameter int CLASS_COUNT     = 4,
  parameter int CAP_COUNT       = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  table_wr_if.writer bus
);
  localparam int N         = CLASS_COUNT * CAP_COUNT;
  localparam int IW        = $clog2(N + 1);
  localparam int ROW_BYTES =
    ((N + `FT_ROW_ALIGN - 1) / `FT_ROW_ALIGN) * `FT_ROW_ALIGN;
  localparam int PA        = PHYS_ADDR_WIDTH;

  writer_state_t          state;
  logic [IW-1:0]          idx;
  logic [8*N-1:0]         caps;
  logic [PA-1:0]          row_base;

  // only enumerated slots get a byte; padding is never written
  function automatic logic [PA-1:0] row_start(
    input logic [PA-13:0] page, input logic [ROW_W-1:0] row);
    row_start = {page, 12'h000} + PA'(row) * PA'(ROW_BYTES);
  endfunction

  function automatic cap_byte_t pick(
    input logic [8*N-1:0] v, input logic [IW-1:0] i);
    pick = v[8*i +: 8];
  endfunction

  wire last_ack  = bus.mem_req && bus.mem_ack && (idx == IW'(N - 1));
  wire next_step = bus.mem_req && bus.mem_ack && !last_ack;
  wire [PA-1:0] start_base = row_start(bus.page, bus.row);

  assign bus.busy = (state != WR_IDLE);
  assign bus.done = (state == WR_DONE);

  always_ff @(posedge clk) begin
    if (!rst_n || bus.abort) begin
      state       <= WR_IDLE;
      idx         <= '0;
      caps        <= '0;
      row_base    <= '0;
      bus.mem_req <= 1'b0;
      bus.mem_addr <= '0;
      bus.mem_data <= 8'h00;
    end else begin
      case (state)
        WR_IDLE: begin
          if (bus.start) begin
            state        <= WR_ISSUE;
            idx          <= '0;
            caps         <= bus.caps;
            row_base     <= start_base;
            bus.mem_req  <= 1'b1;
            bus.mem_addr <= start_base;
            bus.mem_data <= pick(bus.caps, '0);
          end
        end
        WR_ISSUE: begin
          if (last_ack) begin
            state       <= WR_DONE;
            bus.mem_req <= 1'b0;
          end else if (next_step) begin
            // class c perf at c*cap_count, efficiency right after
            idx          <= idx + IW'(1);
            bus.mem_addr <= row_base + PA'(idx) + PA'(1);
            bus.mem_data <= pick(caps, idx + IW'(1));
          end
        end
        default: state <= WR_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || bus.abort);

  sequence s_start;
    state == WR_IDLE && bus.start;
  endsequence

  first_slot_a: assert property (s_start |=> bus.mem_req &&
      bus.mem_addr == $past(start_base))
    else $error("first byte not at row start");
  offset_walk_a: assert property (next_step |=>
      bus.mem_addr == $past(bus.mem_addr) + PA'(1))
    else $error("capability bytes not contiguous");
  value_pass_a: assert property (s_start |=>
      bus.mem_data == $past(bus.caps[7:0]))
    else $error("capability byte altered");
  row_end_a: assert property (last_ack |->
      bus.mem_addr == row_base + PA'(N - 1))
    else $error("last slot at wrong offset");
  row_align_a: assert property (s_start |=>
      bus.mem_addr[2:0] == 3'h0)
    else $error("row not 8 byte aligned");
  done_pulse_a: assert property (last_ack |=> bus.done ##1 !bus.done)
    else $error("done not a single pulse");
endmodule

// File: hw/feedback_table_ptr.sv
// feedback table base pointer register and row update control
// How it works
// - class perf byte at class*capcount
// - zero performance means avoid this processor
// - efficiency byte right after perf byte
// - efficiency 255 marks most efficient processors
// - unenumerated slots take no bytes
// - rows padded to eight byte multiple
// - page frame above bit 12, reserved zero
// - bit 0 flags pointer valid
// - pointer at MSR 17D0H, package wide
// - reset clears pointer, INIT keeps it
// - table size reported in EDX[11:8]
// - ready status bit 26 set when done
`timescale 1ns/1ps
`include "feedback_cfg.svh"
module feedback_table_ptr
  import feedback_pkg::*;
#(
  parameter int PHYS_ADDR_WIDTH = 46,
  parameter int ROW_W           = 8,
  parameter int CLASS_COUNT     = 4,
  parameter int CAP_COUNT       = 2,
  parameter logic [3:0] TABLE_PAGES = 4'h1
) (
  input  wire logic                               SYS_CLK,
  input  wire logic                               RST_N,
  input  wire logic                               INIT,
  input  wire logic                               MSR_WR,
  input  wire logic                               MSR_RD,
  input  wire logic [31:0]                        MSR_ADDR,
  input  wire logic [63:0]                        MSR_WDATA,
  output      logic [63:0]                        MSR_RDATA,
  output      logic                               MSR_ACK,
  output      logic                               MSR_FAULT,
  input  wire logic                               FEATURE_ENABLE,
  input  wire logic                               UPDATE_REQ,
  input  wire logic [ROW_W-1:0]                   UPDATE_ROW,
  input  wire logic [8*CLASS_COUNT*CAP_COUNT-1:0] UPDATE_CAPS,
  output      logic                               UPDATE_BUSY,
  input  wire logic                               READY_CLEAR,
  output      logic                               TABLE_READY,
  output      logic [31:0]                        SIZE_EDX,
  output      logic                               MEM_REQ,
  output      logic [63:0]                        MEM_ADDR,
  output      logic [7:0]                         MEM_DATA,
  input  wire logic                               MEM_ACK
);
  localparam int PA = PHYS_ADDR_WIDTH;
  localparam int N  = CLASS_COUNT * CAP_COUNT;

  logic [63:0] ptr;
  logic        ready;
  logic        enable_q;
  logic [63:0] rdata;
  logic        ack;
  logic        fault;

  table_wr_if #(
    .PHYS_ADDR_WIDTH (PA),
    .ROW_W           (ROW_W),
    .CAP_BYTES       (N)
  ) wr ();

  row_writer #(
    .PHYS_ADDR_WIDTH (PA),
    .ROW_W           (ROW_W),
    .CLASS_COUNT     (CLASS_COUNT),
    .CAP_COUNT       (CAP_COUNT)
  ) u_writer (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .bus   (wr.writer)
  );

  // writable: page frame field and valid bit; the rest reads zero
  function automatic logic [63:0] ptr_mask();
    logic [63:0] m;
    m = '0;
    m[PA-1:`FT_PTR_PAGE_LSB] = '1;
    m[`FT_PTR_VALID_BIT] = 1'b1;
    ptr_mask = m;
  endfunction

  wire hit_ptr   = (MSR_ADDR == `FT_PTR_MSR_ADDR);
  wire ptr_write = MSR_WR && hit_ptr;
  wire ptr_valid = ptr[`FT_PTR_VALID_BIT];
  wire allowed   = ptr_valid && FEATURE_ENABLE;
  // INIT wins over a start in the same cycle: no half-started row
  wire do_start  = UPDATE_REQ && allowed && !INIT && !wr.busy;
  // dropping valid or enable stops memory traffic mid row
  wire do_abort  = !allowed || INIT;
  wire disabled  = enable_q && !FEATURE_ENABLE;
  wire set_ready = wr.done || disabled;
  wire [63:0] next_ptr = MSR_WDATA & ptr_mask();

  assign wr.start   = do_start;
  assign wr.abort   = do_abort;
  assign wr.row     = UPDATE_ROW;
  assign wr.page    = ptr[PA-1:`FT_PTR_PAGE_LSB];
  assign wr.caps    = UPDATE_CAPS;
  assign wr.mem_ack = MEM_ACK;

  assign UPDATE_BUSY = wr.busy;
  assign TABLE_READY = ready;
  assign MEM_REQ     = wr.mem_req;
  assign MEM_ADDR    = {{(64 - PA){1'b0}}, wr.mem_addr};
  assign MEM_DATA    = wr.mem_data;
  assign MSR_RDATA   = rdata;
  assign MSR_ACK     = ack;
  assign MSR_FAULT   = fault;

  // table size in pages; other bits of the leaf belong elsewhere
  assign SIZE_EDX = {20'h00000, TABLE_PAGES, 8'h00};

  // INIT deliberately absent: pointer survives it
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ptr <= `FT_PTR_RESET;
    end else if (ptr_write) begin
      ptr <= next_ptr;
    end
  end

  // hardware set wins over a clear in the same cycle
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ready <= 1'b0;
    end else if (set_ready) begin
      ready <= 1'b1;
    end else if (READY_CLEAR) begin
      ready <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      enable_q <= 1'b0;
    end else begin
      enable_q <= FEATURE_ENABLE;
    end
  end

  // one-cycle answer; unmapped addresses fault like a #GP
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      rdata <= 64'h0000_0000_0000_0000;
      ack   <= 1'b0;
      fault <= 1'b0;
    end else begin
      ack   <= MSR_RD || MSR_WR;
      fault <= (MSR_RD || MSR_WR) && !hit_ptr;
      if (MSR_RD && hit_ptr) begin
        rdata <= ptr;
      end else begin
        rdata <= 64'h0000_0000_0000_0000;
      end
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_ptr_wr;
    ptr_write;
  endsequence

  sequence s_rd_back;
    MSR_RD && hit_ptr;
  endsequence

  sequence s_msr_any;
    MSR_RD || MSR_WR;
  endsequence

  property p_reserved_zero;
    s_ptr_wr |=> ptr[`FT_PTR_PAGE_LSB-1:1] == 11'h000 &&
                 ptr == ($past(MSR_WDATA) & ptr_mask());
  endproperty

  reserved_bits_a: assert property (p_reserved_zero)
    else $error("reserved pointer bits not zero");
  read_back_a: assert property (s_rd_back |=>
      MSR_ACK && !MSR_FAULT && MSR_RDATA == $past(ptr))
    else $error("pointer read back wrong");
  unmapped_fault_a: assert property ((MSR_RD || MSR_WR) && !hit_ptr
      |=> MSR_ACK && MSR_FAULT && MSR_RDATA == 64'h0)
    else $error("unmapped access not faulted");
  init_keeps_a: assert property (INIT && !ptr_write |=>
      $stable(ptr))
    else $error("pointer changed on INIT");
  reset_clear_a: assert property (@(posedge SYS_CLK) disable iff (1'b0)
      !RST_N |=> ptr == 64'h0 && !TABLE_READY)
    else $error("reset did not clear pointer");
  gated_write_a: assert property (MEM_REQ |-> ptr_valid &&
      $past(FEATURE_ENABLE))
    else $error("table write while not allowed");
  valid_start_a: assert property (!ptr_valid |-> !wr.start)
    else $error("update started without valid");
  ready_set_a: assert property (wr.done |=> TABLE_READY)
    else $error("ready not set after row");
  page_base_a: assert property (wr.start |=>
      MEM_ADDR[PA-1:12] >= $past(ptr[PA-1:12]))
    else $error("row below table base");
  size_report_a: assert property (SIZE_EDX[11:8] == TABLE_PAGES)
    else $error("table size misreported");
  msr_answer_a: assert property (s_msr_any |=> MSR_ACK)
    else $error("access not acknowledged");
  msr_quiet_a: assert property (!MSR_RD && !MSR_WR |=>
      !MSR_ACK && !MSR_FAULT && MSR_RDATA == 64'h0)
    else $error("answer without access");
  abort_stop_a: assert property (do_abort |=> !MEM_REQ)
    else $error("table write after abort");
  ready_hold_a: assert property (TABLE_READY && !READY_CLEAR |=>
      TABLE_READY)
    else $error("ready flag dropped by itself");
  ready_clear_a: assert property (READY_CLEAR && !set_ready |=>
      !TABLE_READY)
    else $error("ready flag not cleared");
endmodule

// File: verif/table_mem.sv
// system memory beside the row writer, prompt or slow to take bytes
`timescale 1ns/1ps
module table_mem (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic [63:0] mem_addr,
  input  wire logic [7:0]  mem_data,
  output      logic        mem_ack
);
  // empty map: no table byte written yet; an unwritten byte reads as X, not zero
  logic [7:0] mem [logic [63:0]];
  int         wait_n;
  initial begin
    mem_ack = 1'b0;
    wait_n  = 0;
  end
  always @(posedge clk) begin
    if (mem_ack && mem_req) begin
      mem[mem_addr] = mem_data;
      wait_n = slow ? $urandom_range(3, 0) : 0;
    end else if (wait_n > 0) begin
      wait_n--;
    end
    // later than the bench's drive step, so reset is seen settled
    #2 mem_ack = rst_n && mem_req && (wait_n == 0);
  end
endmodule

// File: verif/feedback_table_ptr_tb.sv
// self-checking bench of the feedback table pointer block
`timescale 1ns/1ps
module feedback_table_ptr_tb;
  localparam int          PA  = 46;
  localparam int          N   = 6;
  localparam logic [31:0] PTR = 32'h0000_17D0;
  logic          sys_clk = 1'b0;
  logic          rst_n   = 1'b0;
  logic          init    = 1'b0;
  logic          msr_wr  = 1'b0;
  logic          msr_rd  = 1'b0;
  logic [31:0]   msr_addr  = 32'h0;
  logic [63:0]   msr_wdata = 64'h0;
  logic          feat_en = 1'b0;
  logic          upd_req = 1'b0;
  logic          rdy_clr = 1'b0;
  logic          slow    = 1'b0;
  logic [7:0]    upd_row = 8'h0;
  logic [8*N-1:0] upd_caps = '0;
  logic [63:0]   msr_rdata, mem_addr, ptr, rd, d;
  logic [31:0]   size_edx;
  logic [7:0]    mem_data;
  logic          msr_ack, msr_fault, upd_busy, table_ready;
  logic          mem_req, mem_ack, flt;
  int            n_fail = 0;
  int            checked = 0;
  int            cycles = 0;

  always #2 sys_clk = ~sys_clk;

  feedback_table_ptr #(.CLASS_COUNT(2), .CAP_COUNT(3), .TABLE_PAGES(4'h3))
    u_dut (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .INIT(init),
    .MSR_WR(msr_wr), .MSR_RD(msr_rd), .MSR_ADDR(msr_addr),
    .MSR_WDATA(msr_wdata), .MSR_RDATA(msr_rdata), .MSR_ACK(msr_ack),
    .MSR_FAULT(msr_fault), .FEATURE_ENABLE(feat_en),
    .UPDATE_REQ(upd_req), .UPDATE_ROW(upd_row), .UPDATE_CAPS(upd_caps),
    .UPDATE_BUSY(upd_busy), .READY_CLEAR(rdy_clr),
    .TABLE_READY(table_ready), .SIZE_EDX(size_edx), .MEM_REQ(mem_req),
    .MEM_ADDR(mem_addr), .MEM_DATA(mem_data), .MEM_ACK(mem_ack));

  table_mem u_mem (
    .clk(sys_clk), .rst_n(rst_n), .slow(slow), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_data(mem_data), .mem_ack(mem_ack));

  task automatic conclude();
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // generous ceiling: the whole run needs well under 2000 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic msr(input logic wr, input logic [31:0] a,
                     input logic [63:0] v);
    @(posedge sys_clk) #1;
    msr_wr = wr;
    msr_rd = !wr;
    msr_addr = a;
    msr_wdata = v;
    @(posedge sys_clk) #1;
    msr_wr = 1'b0;
    msr_rd = 1'b0;
    rd = msr_rdata;
    flt = msr_fault;
    chk(64'(msr_ack), 64'h1);
    chk(64'(flt), 64'(a != PTR));
  endtask

  function automatic logic [63:0] mask(input logic [63:0] v);
    mask = v & {{(64-PA){1'b0}}, {(PA-12){1'b1}}, 11'h0, 1'b1};
  endfunction

  // rows are N bytes rounded up to a multiple of eight
  function automatic logic [63:0] row_base(input logic [7:0] r);
    row_base = {ptr[63:12], 12'h000} + 64'(r) * 64'((N + 7) / 8 * 8);
  endfunction

  task automatic row(input logic [7:0] r, input logic [8*N-1:0] c,
                     input logic go);
    u_mem.mem.delete();
    @(posedge sys_clk) #1;
    upd_req = 1'b1;
    rdy_clr = 1'b1;
    upd_row = r;
    upd_caps = c;
    @(posedge sys_clk) #1;
    upd_req = 1'b0;
    rdy_clr = 1'b0;
    chk(64'(upd_busy), 64'(go));
    for (int i = 0; i < 200 && upd_busy !== 1'b0; i++)
      @(posedge sys_clk) #1;
    repeat (2) @(posedge sys_clk) #1;
    chk(64'(table_ready), 64'(go));
    chk(64'(u_mem.mem.num()), go ? 64'(N) : 64'h0);
    for (int k = 0; k < N && go; k++)
      chk(64'(u_mem.mem[row_base(r)+64'(k)]), 64'(c[8*k+:8]));
  endtask

  initial begin
    void'($urandom(95265));
    repeat (20) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    msr(1'b0, PTR, 64'h0);
    chk(rd, 64'h0);
    chk(64'(size_edx), 64'h300);
    ptr = 64'h0;
    feat_en = 1'b1;
    row(8'h00, '1, 1'b0);
    repeat (4) begin
      d = {$urandom, $urandom};
      msr(1'b1, PTR, d);
      msr(1'b0, PTR, 64'h0);
      chk(rd, mask(d));
    end
    msr(1'b1, PTR + 32'h1, '1);
    chk(64'(flt), 64'h1);
    msr(1'b0, PTR + 32'h1, 64'h0);
    chk(rd, 64'h0);
    msr(1'b0, PTR, 64'h0);
    chk(rd, mask(d));
    // software programs a valid base before the enabled rows that must write
    ptr = mask({$urandom, $urandom} | 64'h1);
    msr(1'b1, PTR, ptr);
    // disable and a clear in one cycle: the set must win
    feat_en = 1'b0;
    rdy_clr = 1'b1;
    @(posedge sys_clk) #1;
    rdy_clr = 1'b0;
    repeat (2) @(posedge sys_clk) #1;
    chk(64'(table_ready), 64'h1);
    row(8'h01, 48'h123456789ABC, 1'b0);
    feat_en = 1'b1;
    row(8'h02, '0, 1'b1);
    row(8'hFF, '1, 1'b1);
    row(8'h00, {3{16'h00FF}}, 1'b1);
    repeat (8) begin
      slow = 1'($urandom);
      row(8'($urandom), 48'({$urandom, $urandom}), 1'b1);
    end
    // INIT in mid-row: row lost, pointer kept
    slow = 1'b1;
    @(posedge sys_clk) #1;
    upd_req = 1'b1;
    rdy_clr = 1'b1;
    @(posedge sys_clk) #1;
    upd_req = 1'b0;
    rdy_clr = 1'b0;
    init = 1'b1;
    @(posedge sys_clk) #1;
    init = 1'b0;
    repeat (4) @(posedge sys_clk) #1;
    chk(64'(table_ready), 64'h0);
    msr(1'b0, PTR, 64'h0);
    chk(rd, ptr);
    rst_n = 1'b0;
    repeat (2) @(posedge sys_clk) #1;
    rst_n = 1'b1;
    msr(1'b0, PTR, 64'h0);
    chk(rd, 64'h0);
    conclude();
  end
endmodule
